// ==== src/osbt_blink.sv ====
// blink pattern block: on/off sequencer with end conditions
`timescale 1ns/100ps
`default_nettype none
module osbt_blink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scan_i,
  input wire logic adv_i,
  input wire logic trig_i,
  input wire logic [1:0] mode_i,
  input wire osbt_pkg::osbt_bcfg_type cfg_i,
  output logic out_o,
  output osbt_pkg::osbt_bstat_type stat_o
);
  import osbt_pkg::*;
  osbt_bstate_type st_q; // sequencer state
  logic [TW-1:0] on_q; // on elapsed
  logic [TW-1:0] off_q; // off elapsed
  logic [TW-1:0] prog_q; // cycles or units done
  logic [TW-1:0] on_inc;
  logic [TW-1:0] off_inc;
  logic [TW-1:0] prog_inc;
  logic time_end;
  assign on_inc = on_q + 15'h0001;
  assign off_inc = off_q + 15'h0001;
  assign prog_inc = prog_q + 15'h0001;
  // total time reached in time-limited mode
  assign time_end = (mode_i == MODE_TIME) && adv_i && (prog_inc >= cfg_i.lim_pre);
  assign out_o = (st_q == BL_ON);
  assign stat_o = '{on_el: on_q, off_el: off_q, prog: prog_q, done: st_q == BL_DONE};
  // sequencer, stepped once per scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= BL_IDLE;
      on_q <= PRE_RST;
      off_q <= PRE_RST;
      prog_q <= PRE_RST;
    end else if (scan_i) begin
      if (!trig_i) begin
        st_q <= BL_IDLE;
        on_q <= PRE_RST;
        off_q <= PRE_RST;
        prog_q <= PRE_RST;
      end else begin
        if (mode_i == MODE_TIME && adv_i && (st_q == BL_ON || st_q == BL_OFF)) begin
          prog_q <= prog_inc;
        end
        unique case (st_q)
          BL_IDLE: begin
            st_q <= BL_ON;
          end
          BL_ON: begin
            if (time_end) begin
              st_q <= BL_DONE;
            end else if (cfg_i.on_pre == PRE_RST || (adv_i && on_inc >= cfg_i.on_pre)) begin
              st_q <= BL_OFF;
              on_q <= PRE_RST;
            end else if (adv_i) begin
              on_q <= on_inc;
            end
          end
          BL_OFF: begin
            if (time_end) begin
              st_q <= BL_DONE;
            end else if (cfg_i.off_pre == PRE_RST || (adv_i && off_inc >= cfg_i.off_pre)) begin
              off_q <= PRE_RST;
              if (mode_i == MODE_COUNT) begin
                prog_q <= prog_inc;
                st_q <= (prog_inc >= cfg_i.lim_pre) ? BL_DONE : BL_ON;
              end else begin
                st_q <= BL_ON;
              end
            end else if (adv_i) begin
              off_q <= off_inc;
            end
          end
          BL_DONE: begin
            st_q <= BL_DONE; // hold off until trigger falls
          end
        endcase
      end
    end
  end
endmodule : osbt_blink
`default_nettype wire

// ==== src/osbt_pkg.sv ====
// constants, types and operation summary for the one-shot and blink timers
// Operation
// - pulse unit selectable 10ms, 100ms or 1s
// - pulse preset ranges zero to 32767 units
// - trigger rise drives output on for preset
// - clear forces output off, beats trigger
// - zero preset behaves as plain pulse block
// - pulse holds time or input priority setting
// - pulse preset and elapsed time readable
// - blink has separate on and off presets
// - cycle-limited mode stops after programmed cycles
// - time-limited mode stops after programmed duration
// - continuous mode repeats with no end
// - blink runs while trigger on, off otherwise
// - blink presets and progress values readable
package osbt_pkg;
  // timer value width, max 32767 units
  localparam int unsigned TW = 15;
  // base tick figures, clock 40 MHz
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BASE_MS = 10;
  localparam int unsigned BASE_CYC = CLK_HZ / 1000 * BASE_MS;
  // decade steps from 10ms to 100ms to 1s
  localparam logic [3:0] DECADE = 4'hA;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PLS_PRE = 8'h04;
  localparam logic [7:0] OFS_PLS_EL = 8'h08;
  localparam logic [7:0] OFS_ON_PRE = 8'h0C;
  localparam logic [7:0] OFS_ON_EL = 8'h10;
  localparam logic [7:0] OFS_OFF_PRE = 8'h14;
  localparam logic [7:0] OFS_OFF_EL = 8'h18;
  localparam logic [7:0] OFS_LIM_PRE = 8'h1C;
  localparam logic [7:0] OFS_LIM_PROG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // control field positions
  localparam int unsigned CTRL_PUNIT = 0;
  localparam int unsigned CTRL_BUNIT = 2;
  localparam int unsigned CTRL_PRIO = 4;
  localparam int unsigned CTRL_MODE = 5;
  localparam int unsigned CTRL_BITS = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [TW-1:0] PRE_RST = 15'h0000;
  // status bit positions
  localparam int unsigned ST_PULSE = 0;
  localparam int unsigned ST_BLINK = 1;
  localparam int unsigned ST_DONE = 2;
  // time unit choice
  typedef enum logic [1:0] {
    UNIT_10MS = 2'b00,
    UNIT_100MS = 2'b01,
    UNIT_1S = 2'b10
  } osbt_unit_type;
  // blink end condition
  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_COUNT = 2'b01,
    MODE_TIME = 2'b10
  } osbt_mode_type;
  // blink sequencer states
  typedef enum logic [1:0] {
    BL_IDLE = 2'b00,
    BL_ON = 2'b01,
    BL_OFF = 2'b10,
    BL_DONE = 2'b11
  } osbt_bstate_type;
  // blink presets carried together
  typedef struct packed {
    logic [TW-1:0] on_pre;
    logic [TW-1:0] off_pre;
    logic [TW-1:0] lim_pre;
  } osbt_bcfg_type;
  // blink observed values carried together
  typedef struct packed {
    logic [TW-1:0] on_el;
    logic [TW-1:0] off_el;
    logic [TW-1:0] prog;
    logic done;
  } osbt_bstat_type;
endpackage : osbt_pkg

// ==== src/osbt_pulse.sv ====
// single pulse block: timed one-shot with clear and priority
`timescale 1ns/100ps
`default_nettype none
module osbt_pulse (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scan_i,
  input wire logic adv_i,
  input wire logic trig_i,
  input wire logic clr_i,
  input wire logic prio_in_i,
  input wire logic [osbt_pkg::TW-1:0] pre_i,
  output logic out_o,
  output logic [osbt_pkg::TW-1:0] el_o
);
  import osbt_pkg::*;
  logic out_q; // pulse output
  logic [TW-1:0] el_q; // elapsed units
  logic trig_q; // trigger at previous scan
  logic [TW-1:0] el_inc;
  assign el_inc = el_q + 15'h0001;
  assign out_o = out_q;
  assign el_o = el_q;
  // previous trigger, sampled only at scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
    end else if (scan_i) begin
      trig_q <= trig_i;
    end
  end
  // pulse sequencing, evaluated once per scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      el_q <= PRE_RST;
    end else if (scan_i) begin
      if (clr_i) begin
        out_q <= 1'b0;
        el_q <= PRE_RST;
      end else if (!out_q && trig_i && !trig_q) begin
        // a zero preset gives one scan of output, like the plain pulse block
        out_q <= 1'b1;
        el_q <= PRE_RST;
      end else if (out_q) begin
        if (pre_i == PRE_RST) begin
          out_q <= 1'b0;
        end else if (prio_in_i && !trig_i) begin
          out_q <= 1'b0;
        end else if (adv_i) begin
          el_q <= el_inc;
          // presets below one scan give a stretched pulse
          if (el_inc >= pre_i) begin
            out_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule : osbt_pulse
`default_nettype wire

// ==== src/osbt_top.sv ====
// top: wishbone register file, time base and the two timer blocks
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module osbt_top #(
  // cycles per 10ms base tick, shorten in simulation
  parameter int unsigned BASE_CYCLES = osbt_pkg::BASE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scan_i,
  input wire logic pulse_trig_i,
  input wire logic pulse_clr_i,
  input wire logic blink_trig_i,
  output logic pulse_o,
  output logic blink_o
);
  import osbt_pkg::*;

  // merge write data into a register under byte enables
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] din,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return r;
  endfunction : wr_merge

  // pick the pending tick of the chosen unit
  function automatic logic unit_pick(input logic [1:0] u, input logic [2:0] pend);
    logic r;
    r = pend[2];
    unique case (u)
      UNIT_10MS: r = pend[0];
      UNIT_100MS: r = pend[1];
      default: r = pend[2]; // unused code runs as 1s
    endcase
    return r;
  endfunction : unit_pick

  // widen a timer value to a bus word
  function automatic logic [31:0] to_word(input logic [TW-1:0] v);
    return {17'h0_0000, v};
  endfunction : to_word

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  logic ack_q; // answer strobe
  logic [31:0] rdat_q; // registered read data
  logic bus_req; // new request this cycle
  logic bus_wr; // write taken this cycle
  logic [31:0] rd_mux; // read data selected by address

  // software registers
  logic [CTRL_BITS-1:0] ctrl_q; // units, priority, mode
  logic [TW-1:0] pls_pre_q; // pulse preset
  osbt_bcfg_type bcfg_q; // blink presets

  // time base
  logic [31:0] base_cnt_q; // cycles in 10ms
  logic [3:0] dec1_q; // 10ms ticks in 100ms
  logic [3:0] dec2_q; // 100ms ticks in 1s
  logic [2:0] tick; // one-cycle unit ticks
  logic [2:0] pend_q; // ticks not yet seen by a scan

  // timer block results
  logic pls_out;
  logic [TW-1:0] pls_el;
  logic blk_out;
  osbt_bstat_type bstat;
  logic pls_q; // registered pulse output
  logic blk_q; // registered blink output

  // a request is answered one cycle later; ack drops after one cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pulse_o = pls_q;
  assign blink_o = blk_q;

  // ack generation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CTRL: rd_mux = {25'h000_0000, ctrl_q};
      OFS_PLS_PRE: rd_mux = to_word(pls_pre_q);
      OFS_PLS_EL: rd_mux = to_word(pls_el);
      OFS_ON_PRE: rd_mux = to_word(bcfg_q.on_pre);
      OFS_ON_EL: rd_mux = to_word(bstat.on_el);
      OFS_OFF_PRE: rd_mux = to_word(bcfg_q.off_pre);
      OFS_OFF_EL: rd_mux = to_word(bstat.off_el);
      OFS_LIM_PRE: rd_mux = to_word(bcfg_q.lim_pre);
      OFS_LIM_PROG: rd_mux = to_word(bstat.prog);
      OFS_STATUS: rd_mux = {29'h0000_0000, bstat.done, blk_q, pls_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured with a read request, held until the next read request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      rdat_q <= rd_mux;
    end
  end

  // control register: units, priority, blink mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (bus_wr && wb_adr_i == OFS_CTRL) begin
      // upper bus bits have no storage here, so the cast keeps only the field bits
      ctrl_q <= CTRL_BITS'(wr_merge({25'h000_0000, ctrl_q}, wb_dat_i, wb_sel_i));
    end
  end

  // pulse preset, range 0..32767 units
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pls_pre_q <= PRE_RST;
    end else if (bus_wr && wb_adr_i == OFS_PLS_PRE) begin
      pls_pre_q <= TW'(wr_merge(to_word(pls_pre_q), wb_dat_i, wb_sel_i));
    end
  end

  // blink presets: on, off, cycle or time limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcfg_q <= '{on_pre: PRE_RST, off_pre: PRE_RST, lim_pre: PRE_RST};
    end else if (bus_wr) begin
      if (wb_adr_i == OFS_ON_PRE) begin
        bcfg_q.on_pre <= TW'(wr_merge(to_word(bcfg_q.on_pre), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFS_OFF_PRE) begin
        bcfg_q.off_pre <= TW'(wr_merge(to_word(bcfg_q.off_pre), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFS_LIM_PRE) begin
        bcfg_q.lim_pre <= TW'(wr_merge(to_word(bcfg_q.lim_pre), wb_dat_i, wb_sel_i));
      end
    end
  end

  // ---------------------------------------------------------------
  // time base: 10ms base, then two decade stages
  // ---------------------------------------------------------------
  assign tick[0] = (base_cnt_q == BASE_CYCLES - 1);
  assign tick[1] = tick[0] && (dec1_q == DECADE - 4'h1);
  assign tick[2] = tick[1] && (dec2_q == DECADE - 4'h1);

  // base divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_cnt_q <= 32'h0000_0000;
    end else if (tick[0]) begin
      base_cnt_q <= 32'h0000_0000;
    end else begin
      base_cnt_q <= base_cnt_q + 32'h0000_0001;
    end
  end

  // decade stages for 100ms and 1s
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec1_q <= 4'h0;
      dec2_q <= 4'h0;
    end else if (tick[0]) begin
      dec1_q <= tick[1] ? 4'h0 : dec1_q + 4'h1;
      if (tick[1]) begin
        dec2_q <= tick[2] ? 4'h0 : dec2_q + 4'h1;
      end
    end
  end

  // ticks wait for the next scan; a tick landing on the scan cycle is kept.
  // more than one tick between scans counts once, hence the scan period limit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 3'h0;
    end else if (scan_i) begin
      pend_q <= tick;
    end else begin
      pend_q <= pend_q | tick;
    end
  end

  // ---------------------------------------------------------------
  // timer blocks
  // ---------------------------------------------------------------
  osbt_pulse osbt_pulse_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scan_i(scan_i),
    .adv_i(unit_pick(ctrl_q[CTRL_PUNIT +: 2], pend_q)),
    .trig_i(pulse_trig_i),
    .clr_i(pulse_clr_i),
    .prio_in_i(ctrl_q[CTRL_PRIO]),
    .pre_i(pls_pre_q),
    .out_o(pls_out),
    .el_o(pls_el)
  );

  osbt_blink osbt_blink_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scan_i(scan_i),
    .adv_i(unit_pick(ctrl_q[CTRL_BUNIT +: 2], pend_q)),
    .trig_i(blink_trig_i),
    .mode_i(ctrl_q[CTRL_MODE +: 2]),
    .cfg_i(bcfg_q),
    .out_o(blk_out),
    .stat_o(bstat)
  );

  // output flops, one cycle behind the blocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pls_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      pls_q <= pls_out;
      blk_q <= blk_out;
    end
  end
endmodule : osbt_top
`default_nettype wire

// ==== test/osbt_ctl_model.sv ====
// far side model: controller scan strobe and input pins
`timescale 1ns/100ps
`default_nettype none
module osbt_ctl_model #(
  parameter int unsigned SCAN = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] want_i,
  output logic scan_o,
  output logic pulse_trig_o,
  output logic pulse_clr_o,
  output logic blink_trig_o
);
  logic [7:0] cnt_q; // scan period counter
  // one-cycle scan strobe every SCAN cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      scan_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 8'(SCAN - 1)) ? 8'h00 : cnt_q + 8'h01;
      scan_o <= (cnt_q == 8'(SCAN - 1));
    end
  end
  // pins follow the bench request after an edge, like real inputs
  always_ff @(posedge clk_i) begin
    {pulse_trig_o, pulse_clr_o, blink_trig_o} <= rst_i ? 3'b000 : want_i;
  end
endmodule : osbt_ctl_model
`default_nettype wire

// ==== test/osbt_top_monitor.sv ====
// port checker for the one-shot and blink timer top
`timescale 1ns/100ps
`default_nettype none
module osbt_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scan_i,
  input wire logic pulse_trig_i,
  input wire logic pulse_clr_i,
  input wire logic blink_trig_i,
  input wire logic pulse_o,
  input wire logic blink_o
);
  // one clock domain, so one default for all
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a fresh request is answered on the next cycle
  chk_ack_prompt: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  // ack is a single pulse with a request behind it
  chk_ack_single: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o)
    else $error("ack not a single answered pulse");
  // read data only moves together with ack
  chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  // clear at a scan forces the pulse off, whatever the trigger
  chk_clear_wins: assert property (scan_i && pulse_clr_i |-> ##2 !pulse_o)
    else $error("pulse on after clear");
  // the pulse only starts from a trigger seen at a scan
  chk_pulse_cause: assert property ($rose(pulse_o) |-> $past(scan_i, 2) && $past(pulse_trig_i, 2)
    && !$past(pulse_clr_i, 2))
    else $error("pulse started without trigger");
  // outputs move only two edges after a scan strobe
  chk_pulse_scan: assert property ($changed(pulse_o) |-> $past(scan_i, 2))
    else $error("pulse moved off scan");
  chk_blink_scan: assert property ($changed(blink_o) |-> $past(scan_i, 2))
    else $error("blink moved off scan");
  // blink stays off while its trigger is low
  chk_blink_idle: assert property (scan_i && !blink_trig_i |-> ##2 !blink_o)
    else $error("blink on with trigger low");
  // blink comes on only with its trigger high
  chk_blink_start: assert property ($rose(blink_o) |-> $past(blink_trig_i, 2))
    else $error("blink on without trigger");
  cov_pulse: cover property ($rose(pulse_o));
  cov_blink: cover property ($rose(blink_o));
  cov_clear: cover property (scan_i && pulse_clr_i && pulse_trig_i);
endmodule : osbt_top_monitor
bind osbt_top osbt_top_monitor osbt_top_monitor_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_i(scan_i),
  .pulse_trig_i(pulse_trig_i), .pulse_clr_i(pulse_clr_i), .blink_trig_i(blink_trig_i),
  .pulse_o(pulse_o), .blink_o(blink_o)
);
`default_nettype wire

// ==== test/osbt_top_tb.sv ====
// self-checking bench for the one-shot and blink timers
`timescale 1ns/100ps
`default_nettype none
module osbt_top_tb;
  import osbt_pkg::*;
  localparam int BC = 4; // cycles per 10ms tick, shortened
  localparam int SP = 4; // scan period, never longer than a tick
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rd, rdat;
  logic ack, scan, ptrig, pclr, btrig, pout, bout;
  logic [2:0] want = 3'b000; // pulse trigger, clear, blink trigger
  int num_errors = 0;
  int checks_done = 0;
  always #12.5 clk_i = ~clk_i;
  osbt_top #(.BASE_CYCLES(BC)) osbt_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .scan_i(scan), .pulse_trig_i(ptrig), .pulse_clr_i(pclr), .blink_trig_i(btrig),
    .pulse_o(pout), .blink_o(bout));
  osbt_ctl_model #(.SCAN(SP)) osbt_ctl_model_i (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
    .scan_o(scan), .pulse_trig_o(ptrig), .pulse_clr_o(pclr), .blink_trig_o(btrig));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : rng
  // classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    rdat = rd;
    cyc <= 1'b0;
    if (n >= 64) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
  endtask : bus
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask : rc
  // counts the cycles an output stays at level l
  task automatic hold(input bit b, input logic l, output int w);
    w = 0;
    while ((b ? bout : pout) === l && w < 5000) begin
      @(posedge clk_i);
      w++;
    end
  endtask : hold
  task automatic go(input logic [2:0] v);
    @(posedge clk_i);
    want <= v;
  endtask : go
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic t_regs();
    rc("ctrl reset", OFS_CTRL, 32'h0000_0000);
    rc("on reset", OFS_ON_PRE, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
    rc("ctrl rw", OFS_CTRL, 32'h0000_007F);
    bus(1'b1, OFS_PLS_PRE, 32'hFFFF_FFFF);
    rc("pulse max", OFS_PLS_PRE, 32'h0000_7FFF);
    bus(1'b1, OFS_OFF_PRE, 32'hFFFF_FFFF);
    rc("off max", OFS_OFF_PRE, 32'h0000_7FFF);
    bus(1'b1, OFS_LIM_PRE, 32'hFFFF_FFFF);
    rc("limit max", OFS_LIM_PRE, 32'h0000_7FFF);
    bus(1'b1, OFS_ON_EL, 32'h0000_0055);
    rc("on elapsed ro", OFS_ON_EL, 32'h0000_0000);
    bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rc("unmapped", 8'h3C, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  // each unit stretches a three-unit pulse by its own factor
  task automatic t_units();
    int w, u;
    u = 1;
    bus(1'b1, OFS_PLS_PRE, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_CTRL, 32'(i));
      go(3'b100);
      hold(1'b0, 1'b0, w);
      hold(1'b0, 1'b1, w);
      rng("pulse width", 2 * BC * u, 3 * BC * u + SP, w);
      rc("pulse elapsed", OFS_PLS_EL, 32'h0000_0003);
      go(3'b000);
      u = u * 10;
    end
    $display("test units done");
  endtask : t_units
  task automatic t_clear();
    int w;
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, OFS_PLS_PRE, 32'h0000_0014);
    go(3'b100);
    hold(1'b0, 1'b0, w);
    go(3'b110);
    idle(3 * SP);
    chk("clear off", 32'h0000_0000, {31'h0, pout});
    rc("clear elapsed", OFS_PLS_EL, 32'h0000_0000);
    go(3'b010);
    idle(2 * SP);
    go(3'b110);
    idle(3 * SP);
    chk("clear beats trigger", 32'h0000_0000, {31'h0, pout});
    go(3'b000);
    bus(1'b1, OFS_PLS_PRE, 32'h0000_0000);
    go(3'b100);
    hold(1'b0, 1'b0, w);
    hold(1'b0, 1'b1, w);
    rng("zero preset", SP, SP, w);
    go(3'b000);
    $display("test clear done");
  endtask : t_clear
  // input priority cuts the pulse short, time priority does not
  task automatic t_prio();
    int w;
    bus(1'b1, OFS_PLS_PRE, 32'h0000_0014);
    for (int i = 1; i >= 0; i--) begin
      bus(1'b1, OFS_CTRL, 32'(i * 16));
      go(3'b100);
      hold(1'b0, 1'b0, w);
      idle(2 * SP);
      go(3'b000);
      hold(1'b0, 1'b1, w);
      if (i == 1) rng("input prio", 0, 2 * SP, w);
      else rng("time prio", 16 * BC, 20 * BC, w);
    end
    $display("test prio done");
  endtask : t_prio
  task automatic t_count();
    int w;
    bus(1'b1, OFS_CTRL, 32'h0000_0020);
    bus(1'b1, OFS_ON_PRE, 32'h0000_0002);
    bus(1'b1, OFS_OFF_PRE, 32'h0000_0003);
    bus(1'b1, OFS_LIM_PRE, 32'h0000_0002);
    go(3'b001);
    hold(1'b1, 1'b0, w);
    hold(1'b1, 1'b1, w);
    rng("on width", BC, 2 * BC + SP, w);
    hold(1'b1, 1'b0, w);
    rng("off width", 2 * BC, 3 * BC + SP, w);
    hold(1'b1, 1'b1, w);
    idle(12 * SP);
    chk("count stop", 32'h0000_0000, {31'h0, bout});
    rc("count done", OFS_STATUS, 32'h0000_0004);
    rc("progress", OFS_LIM_PROG, 32'h0000_0002);
    go(3'b000);
    idle(3 * SP);
    rc("progress cleared", OFS_LIM_PROG, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0040);
    go(3'b001);
    hold(1'b1, 1'b0, w);
    idle(12 * SP);
    chk("time stop", 32'h0000_0000, {31'h0, bout});
    rc("time done", OFS_STATUS, 32'h0000_0004);
    go(3'b000);
    $display("test count done");
  endtask : t_count
  task automatic t_cont();
    int n;
    int w;
    logic p;
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, OFS_ON_PRE, 32'h0000_0001);
    bus(1'b1, OFS_OFF_PRE, 32'h0000_0001);
    bus(1'b1, OFS_LIM_PRE, 32'h0000_0001);
    go(3'b001);
    n = 0;
    p = bout;
    repeat (40 * SP) begin
      @(posedge clk_i);
      if (bout === 1'b1 && p !== 1'b1) n++;
      p = bout;
    end
    rng("cont rises", 10, 40, n);
    go(3'b000);
    idle(3 * SP);
    chk("blink idle", 32'h0000_0000, {31'h0, bout});
    rc("on el cleared", OFS_ON_EL, 32'h0000_0000);
    // blink on the 100ms unit: a full on phase spans one unit tick
    bus(1'b1, OFS_CTRL, 32'h0000_0004);
    go(3'b001);
    hold(1'b1, 1'b0, w);
    hold(1'b1, 1'b1, w);
    hold(1'b1, 1'b0, w);
    hold(1'b1, 1'b1, w);
    rng("blink 100ms on", 10 * BC, 10 * BC, w);
    go(3'b000);
    $display("test cont done");
  endtask : t_cont
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_units();
    t_clear();
    t_prio();
    t_count();
    t_cont();
    complete_run();
  end
  // cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
endmodule : osbt_top_tb
`default_nettype wire
